// ===== shared/ieeesr_pkg.sv
package ieeesr_pkg;
    // status byte bit positions
    localparam int SSB_QUES = 3;
    localparam int SSB_MAV = 4;
    localparam int SSB_ESB = 5;
    localparam int SSB_MSS = 6;
    localparam int SSB_OPER = 7;
    // standard event register bit positions
    localparam int ESR_OPC = 0;
    localparam int ESR_QYE = 2;
    localparam int ESR_DDE = 3;
    localparam int ESR_EXE = 4;
    localparam int ESR_CME = 5;
    localparam int ESR_PON = 7;
    // output queue and error queue sizes
    localparam int OQ_DEPTH = 16;
    localparam int OQ_AW = 4;
    localparam int EQ_DEPTH = 8;
    localparam int EQ_AW = 3;
    // error codes, signed 16 bit
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_CMD = 16'hff9c; // -100
    localparam logic [15:0] ERR_EXEC = 16'hff38; // -200
    localparam logic [15:0] ERR_DEV = 16'hfed4; // -300
    localparam logic [15:0] ERR_OVF = 16'hfea2; // -350
    localparam logic [7:0] RESET_ZERO = 8'h00;

    typedef struct packed {
        logic syntax_err;
        logic range_err;
        logic hw_fault;
        logic query_err;
        logic op_complete;
    } ieeesr_event_t;

    typedef enum logic [1:0] {
        IEEESR_IDLE = 2'b00,
        IEEESR_PON = 2'b01
    } ieeesr_state_t;
endpackage

// ===== rtl/ieeesr_err_queue.sv
`timescale 1ns/100ps
`default_nettype none
module ieeesr_err_queue (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic clear,
    input wire logic push,
    input wire logic [15:0] push_code,
    input wire logic pop,
    output logic [15:0] head_code,
    output logic not_empty
);
    logic [15:0] mem [ieeesr_pkg::EQ_DEPTH];
    logic [ieeesr_pkg::EQ_AW-1:0] wp_reg;
    logic [ieeesr_pkg::EQ_AW-1:0] rp_reg;
    logic [ieeesr_pkg::EQ_AW:0] cnt_reg;
    logic full;
    logic last_slot;
    logic do_pop;
    logic do_push;

    assign full = cnt_reg == (ieeesr_pkg::EQ_AW+1)'(ieeesr_pkg::EQ_DEPTH);
    assign last_slot =
        cnt_reg == (ieeesr_pkg::EQ_AW+1)'(ieeesr_pkg::EQ_DEPTH - 1);
    assign do_pop = pop && cnt_reg != '0;
    // the last free slot is kept for the overflow code
    assign do_push = push && (!full || do_pop) && !(last_slot && !do_pop);

    always_ff @(posedge ref_clk) begin
        if (!rst_n || (clear && clk_en)) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else if (clk_en) begin
            if (push && !do_push && !full) begin
                mem[wp_reg] <= ieeesr_pkg::ERR_OVF; // RULE14
                wp_reg <= wp_reg + 1'b1;
            end else if (do_push) begin
                mem[wp_reg] <= push_code;
                wp_reg <= wp_reg + 1'b1;
            end
            if (do_pop) begin
                rp_reg <= rp_reg + 1'b1; // RULE20
            end
            if ((push && !full) && !do_pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (!(push && (!full || do_pop)) && do_pop) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

    assign head_code = (cnt_reg != '0) ? mem[rp_reg] : ieeesr_pkg::ERR_NONE;
    assign not_empty = cnt_reg != '0;
endmodule
`default_nettype wire

// ===== rtl/ieeesr_status.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// RULE1: latch communication events; host cannot write them
// RULE2: event query returns then clears register
// RULE3: enable command loads event enable mask
// RULE4: power-up sets the power-on flag
// RULE5: status byte holds group summaries and flags
// RULE6: status byte query clears nothing
// RULE7: master summary is unlatched OR of enabled
// RULE8: response bytes kept first-in first-out
// RULE9: message-available set while output queue nonempty
// RULE10: event read clears its summary bit
// RULE11: syntax error enters code -100
// RULE12: range or limit error enters -200
// RULE13: hardware fault enters code -300
// RULE14: error buffer overflow enters code -350
// RULE15: host reads status byte, then events
// RULE16: host masks events it cannot remove
// RULE17: power-up zeros all but power-on flag
// RULE18: zero service mask never sets summary
// RULE19: event summary reported in bit five
// RULE20: error queue oldest first, zero when empty
module ieeesr_status (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire ieeesr_pkg::ieeesr_event_t events,
    input wire logic oper_summary,
    input wire logic ques_summary,
    input wire logic rst_cmd,
    input wire logic cls_cmd,
    input wire logic ese_wr,
    input wire logic sre_wr,
    input wire logic [7:0] wr_data,
    input wire logic esr_rd,
    input wire logic ssb_rd,
    input wire logic oq_push,
    input wire logic [7:0] oq_push_data,
    input wire logic oq_pop,
    input wire logic err_pop,
    output logic [7:0] esr_data,
    output logic [7:0] ese_data,
    output logic [7:0] sre_data,
    output logic [7:0] ssb_data,
    output logic [7:0] oq_head,
    output logic oq_full,
    output logic [15:0] err_code,
    output logic err_pending,
    output logic srq
);
    logic [7:0] esr_reg;
    logic [7:0] esr_next;
    logic [7:0] ese_reg;
    logic [7:0] sre_reg;
    logic [7:0] oq_mem [ieeesr_pkg::OQ_DEPTH];
    logic [ieeesr_pkg::OQ_AW-1:0] oq_wp_reg;
    logic [ieeesr_pkg::OQ_AW-1:0] oq_rp_reg;
    logic [ieeesr_pkg::OQ_AW:0] oq_cnt_reg;
    ieeesr_pkg::ieeesr_state_t state_reg;
    logic [7:0] ev_set;
    logic [7:0] ssb_live;
    logic [7:0] srq_mask;
    logic oq_do_push;
    logic oq_do_pop;
    logic eq_push;
    logic [15:0] eq_code;
    logic [15:0] eq_head;
    logic eq_ne;

    function automatic logic [7:0] ieeesr_bit(input int pos);
        ieeesr_bit = 8'h01 << pos;
    endfunction

    always_comb begin
        ev_set = ieeesr_pkg::RESET_ZERO;
        if (events.syntax_err) ev_set |= ieeesr_bit(ieeesr_pkg::ESR_CME);
        if (events.range_err) ev_set |= ieeesr_bit(ieeesr_pkg::ESR_EXE);
        if (events.hw_fault) ev_set |= ieeesr_bit(ieeesr_pkg::ESR_DDE);
        if (events.query_err) ev_set |= ieeesr_bit(ieeesr_pkg::ESR_QYE);
        if (events.op_complete) ev_set |= ieeesr_bit(ieeesr_pkg::ESR_OPC);
    end

    // new events win over a read-clear in the same cycle
    always_comb begin
        esr_next = esr_reg;
        if (esr_rd || cls_cmd) esr_next = ieeesr_pkg::RESET_ZERO; // RULE2
        if (rst_cmd) begin
            esr_next[ieeesr_pkg::ESR_PON] = 1'b0; // RULE17
        end
        esr_next = esr_next | ev_set; // RULE1
    end

    // power-on flag is set at the first enabled edge after reset release
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg <= ieeesr_pkg::IEEESR_PON;
            esr_reg <= ieeesr_pkg::RESET_ZERO; // RULE17
        end else if (clk_en) begin
            case (state_reg)
                ieeesr_pkg::IEEESR_PON: begin
                    esr_reg <=
                        ev_set | ieeesr_bit(ieeesr_pkg::ESR_PON); // RULE4
                    state_reg <= ieeesr_pkg::IEEESR_IDLE;
                end
                ieeesr_pkg::IEEESR_IDLE: begin
                    esr_reg <= esr_next;
                end
                default: begin
                    state_reg <= ieeesr_pkg::IEEESR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || (rst_cmd && clk_en)) begin
            ese_reg <= ieeesr_pkg::RESET_ZERO;
            sre_reg <= ieeesr_pkg::RESET_ZERO;
        end else if (clk_en) begin
            if (ese_wr) ese_reg <= wr_data; // RULE3
            if (sre_wr) sre_reg <= wr_data;
        end
    end

    // output queue; a push when full is dropped unless a pop comes in the same cycle, host sees oq_full
    assign oq_do_pop = oq_pop && oq_cnt_reg != '0;
    assign oq_do_push = oq_push &&
        (oq_cnt_reg != (ieeesr_pkg::OQ_AW+1)'(ieeesr_pkg::OQ_DEPTH) ||
         oq_do_pop);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            oq_wp_reg <= '0;
            oq_rp_reg <= '0;
            oq_cnt_reg <= '0;
        end else if (clk_en) begin
            if (oq_do_push) begin
                oq_mem[oq_wp_reg] <= oq_push_data; // RULE8
                oq_wp_reg <= oq_wp_reg + 1'b1;
            end
            if (oq_do_pop) oq_rp_reg <= oq_rp_reg + 1'b1; // RULE8
            if (oq_do_push && !oq_do_pop) oq_cnt_reg <= oq_cnt_reg + 1'b1;
            else if (!oq_do_push && oq_do_pop)
                oq_cnt_reg <= oq_cnt_reg - 1'b1;
        end
    end

    // summaries follow the latched registers, so clearing an event
    // register drops its summary bit too
    // mss bit in the mask is ignored; zero mask gives zero mss
    assign srq_mask = sre_reg & ~ieeesr_bit(ieeesr_pkg::SSB_MSS);

    always_comb begin
        ssb_live = ieeesr_pkg::RESET_ZERO;
        ssb_live[ieeesr_pkg::SSB_OPER] = oper_summary; // RULE5
        ssb_live[ieeesr_pkg::SSB_QUES] = ques_summary; // RULE5
        ssb_live[ieeesr_pkg::SSB_MAV] = oq_cnt_reg != '0; // RULE9
        ssb_live[ieeesr_pkg::SSB_ESB] = |(esr_reg & ese_reg); // RULE19 RULE10
        ssb_live[ieeesr_pkg::SSB_MSS] =
            |(ssb_live & srq_mask); // RULE7 RULE18
    end

    // error entry: one code per cycle, by severity
    always_comb begin
        eq_push = 1'b1;
        eq_code = ieeesr_pkg::ERR_NONE;
        if (events.hw_fault) eq_code = ieeesr_pkg::ERR_DEV; // RULE13
        else if (events.range_err) eq_code = ieeesr_pkg::ERR_EXEC; // RULE12
        else if (events.syntax_err) eq_code = ieeesr_pkg::ERR_CMD; // RULE11
        else eq_push = 1'b0;
    end

    ieeesr_err_queue u_errq (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .clear(cls_cmd),
        .push(eq_push),
        .push_code(eq_code),
        .pop(err_pop),
        .head_code(eq_head),
        .not_empty(eq_ne)
    );

    // registered outputs; status byte read has no side effect
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            esr_data <= ieeesr_pkg::RESET_ZERO;
            ese_data <= ieeesr_pkg::RESET_ZERO;
            sre_data <= ieeesr_pkg::RESET_ZERO;
            ssb_data <= ieeesr_pkg::RESET_ZERO;
            oq_head <= ieeesr_pkg::RESET_ZERO;
            oq_full <= 1'b0;
            err_code <= ieeesr_pkg::ERR_NONE;
            err_pending <= 1'b0;
            srq <= 1'b0;
        end else if (clk_en) begin
            esr_data <= esr_reg;
            ese_data <= ese_reg;
            sre_data <= sre_reg;
            ssb_data <= ssb_live; // RULE6
            oq_head <= (oq_cnt_reg != '0) ? oq_mem[oq_rp_reg] :
                ieeesr_pkg::RESET_ZERO;
            oq_full <=
                oq_cnt_reg == (ieeesr_pkg::OQ_AW+1)'(ieeesr_pkg::OQ_DEPTH);
            err_code <= eq_head; // RULE20
            err_pending <= eq_ne;
            srq <= ssb_live[ieeesr_pkg::SSB_MSS];
        end
    end

    logic unused_ssb_rd;
    assign unused_ssb_rd = ssb_rd;
endmodule
`default_nettype wire

// ===== sim/ieeesr_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ieeesr_monitor (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire ieeesr_pkg::ieeesr_event_t events,
    input wire logic ese_wr,
    input wire logic [7:0] wr_data,
    input wire logic esr_rd,
    input wire logic [7:0] esr_data,
    input wire logic [7:0] ese_data,
    input wire logic [7:0] sre_data,
    input wire logic [7:0] ssb_data,
    input wire logic [15:0] err_code,
    input wire logic err_pending,
    input wire logic srq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // a new event in the read cycle wins, so only quiet reads count
    sequence s_quiet_read;
        esr_rd && clk_en && events == '0 ##1 clk_en && events == '0;
    endsequence
    // the output follows the mask only at the next enabled edge
    a_ese_load: assert property (
        ese_wr && clk_en ##1 clk_en |=> ese_data == $past(wr_data, 2))
        else $error("event mask not loaded");
    a_esr_clear: assert property (
        s_quiet_read |=> esr_data == 8'h00)
        else $error("event register not cleared by read");
    a_esb_clear: assert property (
        s_quiet_read ##1 clk_en && events == '0 |=> !ssb_data[5])
        else $error("event summary not cleared by read");
    a_mss_sum: assert property (
        ssb_data[6] == |(ssb_data & sre_data & 8'hbf))
        else $error("master summary wrong");
    a_mss_off: assert property (
        sre_data == 8'h00 |-> !ssb_data[6])
        else $error("master summary with zero mask");
    a_srq_mss: assert property (srq == ssb_data[6])
        else $error("srq differs from master summary");
    a_err_none: assert property (
        !err_pending |-> err_code == 16'h0000)
        else $error("error code without pending error");
    a_reset_zero: assert property (
        disable iff (1'b0) !rst_n |=> esr_data == 8'h00
        && ese_data == 8'h00 && sre_data == 8'h00 && ssb_data == 8'h00)
        else $error("registers not zero in reset");
endmodule
`default_nettype wire

// ===== sim/ieeesr_host.sv
`timescale 1ns/100ps
`default_nettype none
module ieeesr_host (
    input wire logic ref_clk,
    output logic [7:0] strobe,
    output logic [7:0] wr_data
);
    initial begin
        strobe = 8'h00;
        wr_data = 8'h00;
    end
    // strobe: rst cls ese sre esr_rd ssb_rd oq_pop err_pop
    task automatic pulse(input int sel, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        strobe[sel] = 1'b1;
        wr_data = d;
        @(posedge ref_clk);
        #1;
        strobe = 8'h00;
        // released data shows junk so a stale value cannot pass
        wr_data = ~d;
    endtask
endmodule
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic ref_clk, rst_n, clk_en, oper_summary, ques_summary, oq_push;
    logic [7:0] oq_push_data, esr_data, ese_data, sre_data, ssb_data;
    logic [7:0] oq_head, strobe, wr_data;
    logic [15:0] err_code;
    logic oq_full, err_pending, srq;
    ieeesr_pkg::ieeesr_event_t events;
    int miscompares = 0;
    int checks_done = 0;
    localparam logic [7:0] ESR_EXP [5] = '{8'h20, 8'h30, 8'h38, 8'h3c, 8'h3d};
    localparam logic [15:0] EQ_EXP [4] = '{16'hff9c, 16'hff38, 16'hfed4,
        16'hff9c};
    ieeesr_host host (.ref_clk(ref_clk), .strobe(strobe), .wr_data(wr_data));
    ieeesr_status DUT (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
        .events(events), .oper_summary(oper_summary),
        .ques_summary(ques_summary), .rst_cmd(strobe[0]),
        .cls_cmd(strobe[1]), .ese_wr(strobe[2]), .sre_wr(strobe[3]),
        .wr_data(wr_data), .esr_rd(strobe[4]), .ssb_rd(strobe[5]),
        .oq_push(oq_push), .oq_push_data(oq_push_data),
        .oq_pop(strobe[6]), .err_pop(strobe[7]), .esr_data(esr_data),
        .ese_data(ese_data), .sre_data(sre_data), .ssb_data(ssb_data),
        .oq_head(oq_head), .oq_full(oq_full), .err_code(err_code),
        .err_pending(err_pending), .srq(srq));
    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic settle();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task automatic ev(input logic [4:0] v, input int n);
        @(posedge ref_clk);
        #1;
        events = v;
        repeat (n) @(posedge ref_clk);
        #1;
        events = '0;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #100000;
        miscompares++;
        final_report();
    end
    initial begin
        events = '0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        oper_summary = 1'b0;
        ques_summary = 1'b0;
        oq_push = 1'b0;
        oq_push_data = 8'h00;
        repeat (8) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        settle();
        chk("esr", 16'h0080, {8'h00, esr_data});
        chk("ssb", 16'h0000, {8'h00, ssb_data});
        host.pulse(0, 8'h00);
        settle();
        chk("esr", 16'h0000, {8'h00, esr_data});
        for (int i = 0; i < 5; i++) begin
            ev(5'h10 >> i, 1);
            settle();
            chk("esr", {8'h00, ESR_EXP[i]}, {8'h00, esr_data});
        end
        host.pulse(2, 8'hff);
        // a write while the enable is low must not land
        clk_en = 1'b0;
        host.pulse(2, 8'h55);
        clk_en = 1'b1;
        host.pulse(3, 8'h20);
        settle();
        chk("ese", 16'h00ff, {8'h00, ese_data});
        chk("sre", 16'h0020, {8'h00, sre_data});
        chk("ssb", 16'h0060, {8'h00, ssb_data});
        chk("srq", 16'h0001, {15'h0000, srq});
        host.pulse(5, 8'h00);
        settle();
        chk("ssb", 16'h0060, {8'h00, ssb_data});
        host.pulse(3, 8'h00);
        settle();
        chk("ssb", 16'h0020, {8'h00, ssb_data});
        chk("srq", 16'h0000, {15'h0000, srq});
        chk("esr", 16'h003d, {8'h00, esr_data});
        host.pulse(4, 8'h00);
        settle();
        chk("esr", 16'h0000, {8'h00, esr_data});
        chk("ssb", 16'h0000, {8'h00, ssb_data});
        oper_summary = 1'b1;
        ques_summary = 1'b1;
        host.pulse(2, 8'h00);
        host.pulse(3, 8'h08);
        ev(5'h10, 1);
        settle();
        chk("ssb", 16'h00c8, {8'h00, ssb_data});
        for (int i = 0; i < 4; i++) begin
            chk("err", EQ_EXP[i], err_code);
            chk("pend", 16'h0001, {15'h0000, err_pending});
            host.pulse(7, 8'h00);
            settle();
        end
        chk("err", 16'h0000, err_code);
        chk("pend", 16'h0000, {15'h0000, err_pending});
        ev(5'h10, 10);
        settle();
        for (int i = 0; i < 8; i++) begin
            chk("err", i < 7 ? 16'hff9c : 16'hfea2, err_code);
            host.pulse(7, 8'h00);
            settle();
        end
        // clear drops both the event register and pending errors
        ev(5'h08, 1);
        settle();
        chk("pend", 16'h0001, {15'h0000, err_pending});
        host.pulse(1, 8'h00);
        settle();
        chk("esr", 16'h0000, {8'h00, esr_data});
        chk("pend", 16'h0000, {15'h0000, err_pending});
        chk("err", 16'h0000, err_code);
        // one byte more than the queue holds; the last must be dropped
        @(posedge ref_clk);
        for (int i = 0; i <= ieeesr_pkg::OQ_DEPTH; i++) begin
            #1;
            oq_push = 1'b1;
            oq_push_data = 8'ha0 + 8'(i);
            @(posedge ref_clk);
        end
        #1;
        oq_push = 1'b0;
        settle();
        chk("full", 16'h0001, {15'h0000, oq_full});
        for (int i = 0; i < ieeesr_pkg::OQ_DEPTH; i++) begin
            chk("mav", 16'h0001, {15'h0000, ssb_data[4]});
            chk("oq", 16'h00a0 + 16'(i), {8'h00, oq_head});
            host.pulse(6, 8'h00);
            settle();
        end
        chk("mav", 16'h0000, {15'h0000, ssb_data[4]});
        chk("full", 16'h0000, {15'h0000, oq_full});
        // second reset in mid-run: power-on state again
        oper_summary = 1'b0;
        ques_summary = 1'b0;
        host.pulse(2, 8'h3c);
        settle();
        chk("ese", 16'h003c, {8'h00, ese_data});
        rst_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        settle();
        chk("esr", 16'h0080, {8'h00, esr_data});
        chk("ese", 16'h0000, {8'h00, ese_data});
        chk("sre", 16'h0000, {8'h00, sre_data});
        chk("ssb", 16'h0000, {8'h00, ssb_data});
        final_report();
    end
endmodule
bind ieeesr_status ieeesr_monitor mon (.ref_clk(ref_clk), .rst_n(rst_n),
    .clk_en(clk_en), .events(events), .ese_wr(ese_wr), .wr_data(wr_data),
    .esr_rd(esr_rd), .esr_data(esr_data), .ese_data(ese_data),
    .sre_data(sre_data), .ssb_data(ssb_data), .err_code(err_code),
    .err_pending(err_pending), .srq(srq));
`default_nettype wire
